// file: rtl/config_control_pins.sv
// Configuration pin control: restart, init, mode capture, 3-state,
// readback, error/host interrupt pin and pin release at start-up.
// Assumes pins enter through two flip-flops here; one clock domain.
//
// What this block does
// - Program low restarts configuration, resets scan
// - Trigger low during configuration 3-states I/O
// - Option keeps trigger 3-state after configuration while readback is not enabled
// - Trigger falling edge starts readback at frame 0
// - Shared pin: readback data or test data out
// - Error pin low on memory initialization errors in JTAG, slave, master or async mode
// - Host port mode: pin is host interrupt
// - Mode inputs captured on init rising edge
// - PLL clock pins high impedance with pull-up during configuration
// - Unused PLL clock pins become user I/O
// - Unassigned primary clock pins become user I/O
// - No scan selected: scan off, test pins user after configuration
// - Done and other pins released by delays
// - Init low holds wait; device drives during clear
// - Done open-drain output goes high when complete
`timescale 1ns/1ns
module config_control_pins
	import ccp_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        programRestartN,
	input  wire logic        rdCfgN,
	input  wire logic        initIn,
	output logic             initOut,
	output logic             initOe,
	output logic             doneOut,
	output logic             doneOe,
	input  wire logic [3:0]  modeIn,
	input  wire logic        cfgEngineDone,
	input  wire logic        memInitErr,
	input  wire logic        hostIrqReq,
	input  wire logic        rbBit,
	input  wire logic        scanTdo,
	output logic             rdDataTdo,
	output logic             rbActive,
	output logic [15:0]      rbFrameAddr,
	output logic             cfgIrqN,
	output logic             globalTristate,
	output logic             ioActive,
	output logic             scanReset,
	output logic [3:0]       cfgMode,
	output ccp_pins_t        pins,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [31:0]      regRdata,
	output logic             irq
);
	typedef struct packed {
		logic [1:0]  prgSync;
		logic [1:0]  rdSync;
		logic [1:0]  initSync;
		logic [1:0]  errSync;
		logic        rdLast;
		logic        initLast;
		ccp_state_t  state;
		logic [15:0] cnt;
		logic        rbOn;
		logic [15:0] rbAddr;
		logic        errLatched;
		logic [3:0]  mode;
		logic [3:0]  modeSyncA;
		logic [3:0]  modeSyncB;
		logic        doneRel;
		logic        ioRel;
		logic        initDrv;
		logic        gts;
		logic        tdoQ;
		logic        irqPinN;
		logic        scanRst;
		ccp_regs_t   regs;
		ccp_pins_t   pinsQ;
		logic [31:0] rdata;
		logic        irqQ;
	} ccp_ff_t;

	ccp_ff_t st_ff;
	ccp_ff_t nxt_st;
	logic    prgLow;
	logic    rdFall;
	logic    initRise;
	logic    inCfg;
	logic    errMode;
	logic [2:0] ev;

	assign prgLow   = ~st_ff.prgSync[1];
	assign rdFall   = st_ff.rdLast & ~st_ff.rdSync[1];
	assign initRise = ~st_ff.initLast & st_ff.initSync[1];
	assign inCfg    = st_ff.state != S_USER;
	assign errMode  = st_ff.mode == M_JTAG || st_ff.mode == M_SLAVE ||
	                  st_ff.mode == M_MASTER || st_ff.mode == M_ASYNC;

	always_comb begin
		nxt_st = st_ff;
		ev = 3'h0;
		nxt_st.prgSync  = {st_ff.prgSync[0], programRestartN};
		nxt_st.rdSync   = {st_ff.rdSync[0], rdCfgN};
		nxt_st.initSync = {st_ff.initSync[0], initIn};
		nxt_st.errSync  = {st_ff.errSync[0], memInitErr};
		nxt_st.modeSyncA = modeIn;
		nxt_st.modeSyncB = st_ff.modeSyncA;
		nxt_st.rdLast   = st_ff.rdSync[1];
		nxt_st.initLast = st_ff.initSync[1];
		nxt_st.scanRst  = 1'b0;
		case (st_ff.state)
			S_CLEAR: begin
				nxt_st.initDrv = 1'b1;
				nxt_st.doneRel = 1'b0;
				nxt_st.ioRel   = 1'b0;
				if (st_ff.cnt >= 16'(CLEAR_CYC)) begin
					nxt_st.initDrv = 1'b0;
					nxt_st.state   = S_WAIT;
				end else begin
					nxt_st.cnt = st_ff.cnt + 16'h1;
				end
			end
			S_WAIT: begin
				if (initRise) begin
					nxt_st.mode  = st_ff.modeSyncB;
					nxt_st.state = S_CONFIG;
				end
			end
			S_CONFIG: begin
				if (st_ff.errSync[1] && errMode) begin
					nxt_st.errLatched = 1'b1;
				end
				if (st_ff.errSync[1] && errMode) begin
					ev[E_ERR] = 1'b1;
				end
				if (cfgEngineDone) begin
					nxt_st.cnt   = 16'h0;
					nxt_st.state = S_START;
				end
			end
			S_START: begin
				nxt_st.cnt = st_ff.cnt + 16'h1;
				if (st_ff.cnt >= {8'h0, st_ff.regs.doneDly}) begin
					nxt_st.doneRel = 1'b1;
				end
				if (st_ff.cnt >= {8'h0, st_ff.regs.ioDly}) begin
					nxt_st.ioRel = 1'b1;
				end
				if (st_ff.doneRel && st_ff.ioRel) begin
					nxt_st.state = S_USER;
					ev[E_CFGEND] = 1'b1;
				end
			end
			S_USER: begin
				if (st_ff.regs.ctrl[B_RBEN] && rdFall && !st_ff.rbOn) begin
					nxt_st.rbOn   = 1'b1;
					nxt_st.rbAddr = 16'h0;
				end else if (st_ff.rbOn) begin
					nxt_st.rbAddr = st_ff.rbAddr + 16'h1;
					if (st_ff.rbAddr == 16'(RB_BITS - 1)) begin
						nxt_st.rbOn = 1'b0;
						ev[E_RBDONE] = 1'b1;
					end
				end
			end
			default: nxt_st.state = S_CLEAR;
		endcase
		if (prgLow) begin
			nxt_st.state      = S_CLEAR;
			nxt_st.cnt        = 16'h0;
			nxt_st.scanRst    = 1'b1;
			nxt_st.rbOn       = 1'b0;
			nxt_st.errLatched = 1'b0;
			nxt_st.doneRel    = 1'b0;
			nxt_st.ioRel      = 1'b0;
		end
		if (inCfg) begin
			nxt_st.gts = ~st_ff.rdSync[1];
		end else begin
			nxt_st.gts = ~st_ff.rdSync[1] & st_ff.regs.ctrl[B_GTS] &
			             ~st_ff.regs.ctrl[B_RBEN];
		end
		nxt_st.tdoQ = st_ff.rbOn ? rbBit : scanTdo;
		nxt_st.irqPinN = st_ff.regs.ctrl[B_HOST] ? ~hostIrqReq
		                                         : ~st_ff.errLatched;
		nxt_st.pinsQ.pllPullup   = inCfg;
		nxt_st.pinsQ.pllUserIo   = inCfg ? 8'h0 : ~st_ff.regs.pllUsed;
		nxt_st.pinsQ.clkUserIo   = inCfg ? 8'h0 : ~st_ff.regs.clkUsed;
		nxt_st.pinsQ.bscanEnable = inCfg | st_ff.regs.ctrl[B_BSCAN];
		nxt_st.pinsQ.testUserIo  = ~inCfg & ~st_ff.regs.ctrl[B_BSCAN];
		nxt_st.rdata = 32'h0;
		if (regRd) begin
			case (regAddr)
				A_CTRL:  nxt_st.rdata = {28'h0, st_ff.regs.ctrl};
				A_DELAY: nxt_st.rdata = {16'h0, st_ff.regs.ioDly, st_ff.regs.doneDly};
				A_USE:   nxt_st.rdata = {16'h0, st_ff.regs.clkUsed, st_ff.regs.pllUsed};
				A_STAT:  nxt_st.rdata = {21'h0, st_ff.rbOn, st_ff.errLatched,
				                         st_ff.mode, 5'(st_ff.state)};
				A_IRQ:   nxt_st.rdata = {29'h0, st_ff.regs.irqStat};
				A_MASK:  nxt_st.rdata = {29'h0, st_ff.regs.irqMask};
				default: nxt_st.rdata = 32'h0;
			endcase
		end
		if (regWr) begin
			case (regAddr)
				A_CTRL:  nxt_st.regs.ctrl = regWdata[3:0];
				A_DELAY: {nxt_st.regs.ioDly, nxt_st.regs.doneDly} = regWdata[15:0];
				A_USE:   {nxt_st.regs.clkUsed, nxt_st.regs.pllUsed} = regWdata[15:0];
				A_IRQ:   nxt_st.regs.irqStat = st_ff.regs.irqStat & ~regWdata[2:0];
				A_MASK:  nxt_st.regs.irqMask = regWdata[2:0];
				default: nxt_st.regs = st_ff.regs;
			endcase
		end
		nxt_st.regs.irqStat = nxt_st.regs.irqStat | ev;
		nxt_st.irqQ = |(st_ff.regs.irqStat & st_ff.regs.irqMask);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.prgSync <= 2'h3;
			st_ff.rdSync <= 2'h3;
			st_ff.rdLast <= 1'b1;
			st_ff.state <= S_CLEAR;
			st_ff.initDrv <= 1'b1;
			st_ff.irqPinN <= 1'b1;
			st_ff.pinsQ.pllPullup <= 1'b1;
			st_ff.pinsQ.bscanEnable <= 1'b1;
			st_ff.regs.ctrl <= CTRL_RST[3:0];
			st_ff.regs.doneDly <= DELAY_RST[7:0];
			st_ff.regs.ioDly <= DELAY_RST[15:8];
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign initOut        = 1'b0;
	assign initOe         = ~st_ff.initDrv;
	assign doneOut        = 1'b0;
	assign doneOe         = st_ff.doneRel;
	assign rdDataTdo      = st_ff.tdoQ;
	assign rbActive       = st_ff.rbOn;
	assign rbFrameAddr    = st_ff.rbAddr;
	assign cfgIrqN        = st_ff.irqPinN;
	assign globalTristate = st_ff.gts;
	assign ioActive       = st_ff.ioRel;
	assign scanReset      = st_ff.scanRst;
	assign cfgMode        = st_ff.mode;
	assign pins           = st_ff.pinsQ;
	assign regRdata       = st_ff.rdata;
	assign irq            = st_ff.irqQ;

	AST_PRG_RESTART: assert property (@(posedge clock) disable iff (rst)
		!st_ff.prgSync[1] |=> st_ff.state == S_CLEAR && scanReset)
		else $error("program low did not restart");
	AST_GTS_CFG: assert property (@(posedge clock) disable iff (rst)
		inCfg && !st_ff.rdSync[1] && $past(inCfg) |=> globalTristate)
		else $error("no 3-state during configuration");
	AST_GTS_OPT: assert property (@(posedge clock) disable iff (rst)
		!inCfg && !st_ff.regs.ctrl[B_GTS] |=> !globalTristate)
		else $error("3-state without option");
	AST_RB_START: assert property (@(posedge clock) disable iff (rst)
		st_ff.state == S_USER && st_ff.regs.ctrl[B_RBEN] && rdFall && !rbActive
		&& st_ff.prgSync[1] |=> rbActive && rbFrameAddr == 16'h0)
		else $error("readback did not start at frame 0");
	AST_RB_ONCE: assert property (@(posedge clock) disable iff (rst)
		$rose(rbActive) |-> !$past(rbActive, 2) && $past(rdFall))
		else $error("readback start without falling edge");
	AST_ERR_PIN: assert property (@(posedge clock) disable iff (rst)
		st_ff.errLatched && !st_ff.regs.ctrl[B_HOST] |=> !cfgIrqN)
		else $error("error pin not low");
	AST_MODE_CAP: assert property (@(posedge clock) disable iff (rst)
		st_ff.state == S_WAIT && initRise && st_ff.prgSync[1]
		|=> cfgMode == $past(modeIn, 3))
		else $error("mode not captured at init rise");
	AST_PLL_HIZ: assert property (@(posedge clock) disable iff (rst)
		inCfg |=> pins.pllPullup && pins.pllUserIo == 8'h0)
		else $error("PLL pins released during configuration");
	AST_RESTART_CLR: assert property (@(posedge clock) disable iff (rst)
		!st_ff.prgSync[1] |=> !rbActive ##1 cfgIrqN || st_ff.regs.ctrl[B_HOST])
		else $error("restart left readback or error");
	AST_TEST_USER: assert property (@(posedge clock) disable iff (rst)
		!inCfg && !st_ff.regs.ctrl[B_BSCAN] |=> pins.testUserIo && !pins.bscanEnable)
		else $error("test pins not user while scan unused");
	AST_SCAN_ON: assert property (@(posedge clock) disable iff (rst)
		inCfg |=> pins.bscanEnable && !pins.testUserIo)
		else $error("scan not enabled during configuration");
	AST_TDO_RB: assert property (@(posedge clock) disable iff (rst)
		rbActive |=> rdDataTdo == $past(rbBit))
		else $error("readback data not on shared pin");
	AST_TDO_SCAN: assert property (@(posedge clock) disable iff (rst)
		!rbActive |=> rdDataTdo == $past(scanTdo))
		else $error("test data not on shared pin");
	AST_HOST_IRQ: assert property (@(posedge clock) disable iff (rst)
		st_ff.regs.ctrl[B_HOST] |=> cfgIrqN != $past(hostIrqReq))
		else $error("host interrupt not on shared pin");
	AST_ERR_SET: assert property (@(posedge clock) disable iff (rst)
		st_ff.state == S_CONFIG && st_ff.errSync[1] && errMode && st_ff.prgSync[1]
		|=> st_ff.errLatched)
		else $error("memory error not latched");
	AST_PLL_USER: assert property (@(posedge clock) disable iff (rst)
		!inCfg |=> pins.pllUserIo == ~$past(st_ff.regs.pllUsed) && !pins.pllPullup)
		else $error("free PLL pins not user I/O");
	AST_CLK_USER: assert property (@(posedge clock) disable iff (rst)
		!inCfg |=> pins.clkUserIo == ~$past(st_ff.regs.clkUsed))
		else $error("free clock pins not user I/O");
	AST_CLK_HOLD: assert property (@(posedge clock) disable iff (rst)
		inCfg |=> pins.clkUserIo == 8'h0)
		else $error("clock pins user I/O during configuration");
	AST_DONE_DLY: assert property (@(posedge clock) disable iff (rst)
		st_ff.state == S_START && st_ff.cnt >= {8'h0, st_ff.regs.doneDly}
		&& st_ff.prgSync[1] |=> doneOe)
		else $error("done not released after its delay");
	AST_IO_DLY: assert property (@(posedge clock) disable iff (rst)
		st_ff.state == S_START && st_ff.cnt >= {8'h0, st_ff.regs.ioDly}
		&& st_ff.prgSync[1] |=> ioActive)
		else $error("user I/O not released after its delay");
	AST_IO_HOLD: assert property (@(posedge clock) disable iff (rst)
		st_ff.state == S_WAIT || st_ff.state == S_CONFIG |=> !ioActive && !doneOe)
		else $error("pins released before start-up");
	AST_INIT_CLEAR: assert property (@(posedge clock) disable iff (rst)
		st_ff.state == S_CLEAR && st_ff.cnt < 16'(CLEAR_CYC) |=> !initOe)
		else $error("init not driven low while clearing");
	AST_INIT_REL: assert property (@(posedge clock) disable iff (rst)
		st_ff.state == S_WAIT |-> initOe)
		else $error("init driven while waiting");
	AST_WAIT_HOLD: assert property (@(posedge clock) disable iff (rst)
		st_ff.state == S_WAIT && !initRise && st_ff.prgSync[1] |=> st_ff.state == S_WAIT)
		else $error("left wait state without init rise");
	AST_DONE_HIGH: assert property (@(posedge clock) disable iff (rst)
		st_ff.state == S_USER && st_ff.prgSync[1] |=> doneOe)
		else $error("done not released in user state");
	AST_RB_STEP: assert property (@(posedge clock) disable iff (rst)
		rbActive && rdFall && st_ff.prgSync[1] && rbFrameAddr != 16'(RB_BITS - 1)
		|=> rbActive && rbFrameAddr == $past(rbFrameAddr) + 16'h1)
		else $error("trigger edge disturbed running readback");
	AST_RB_END: assert property (@(posedge clock) disable iff (rst)
		rbActive && rbFrameAddr == 16'(RB_BITS - 1) |=> !rbActive)
		else $error("readback ran past last frame");
	AST_RESTART_REL: assert property (@(posedge clock) disable iff (rst)
		!st_ff.prgSync[1] |=> !doneOe && !ioActive)
		else $error("restart left pins released");
endmodule

// file: rtl/ccp_pkg.sv
// Constants, register map and state types of the configuration pin control.
// Assumes one 100 MHz clock and a plain register port with byte addresses.
package ccp_pkg;
	localparam int          CLK_MHZ     = 100;
	localparam int          CLEAR_NS    = 200;
	localparam int          CLEAR_CYC   = (CLEAR_NS * CLK_MHZ + 999) / 1000;
	localparam int          RB_BITS     = 64;
	localparam logic [7:0]  A_CTRL      = 8'h00;
	localparam logic [7:0]  A_DELAY     = 8'h04;
	localparam logic [7:0]  A_USE       = 8'h08;
	localparam logic [7:0]  A_STAT      = 8'h0c;
	localparam logic [7:0]  A_IRQ       = 8'h10;
	localparam logic [7:0]  A_MASK      = 8'h14;
	localparam int          B_RBEN      = 0;
	localparam int          B_GTS       = 1;
	localparam int          B_BSCAN     = 2;
	localparam int          B_HOST      = 3;
	localparam int          E_ERR       = 0;
	localparam int          E_RBDONE    = 1;
	localparam int          E_CFGEND    = 2;
	localparam logic [3:0]  M_JTAG      = 4'h5;
	localparam logic [3:0]  M_SLAVE     = 4'h7;
	localparam logic [3:0]  M_MASTER    = 4'h0;
	localparam logic [3:0]  M_ASYNC     = 4'h4;
	localparam logic [31:0] CTRL_RST    = 32'h0000_0004;
	localparam logic [31:0] DELAY_RST   = 32'h0000_0402;
	typedef enum logic [2:0] {S_CLEAR, S_WAIT, S_CONFIG, S_START, S_USER} ccp_state_t;
	typedef struct packed {
		logic [3:0] ctrl;
		logic [7:0] doneDly;
		logic [7:0] ioDly;
		logic [7:0] pllUsed;
		logic [7:0] clkUsed;
		logic [2:0] irqStat;
		logic [2:0] irqMask;
	} ccp_regs_t;
	typedef struct packed {
		logic [7:0] pllUserIo;
		logic [7:0] clkUserIo;
		logic       pllPullup;
		logic       testUserIo;
		logic       bscanEnable;
	} ccp_pins_t;
endpackage

// file: dv/ccp_board_model.sv
// Board side model: restart pin, trigger pin, init wire, mode straps.
// Assumes bench commands on its inputs; the init wire has a pull-up.
`timescale 1ns/1ns
module ccp_board_model (
	input  wire logic       initOe,
	input  wire logic       progLow,
	input  wire logic       holdInit,
	input  wire logic       trigLow,
	input  wire logic [3:0] modeSet,
	output logic            programRestartN,
	output logic            rdCfgN,
	output logic            initIn,
	output logic [3:0]      modeIn,
	output logic            testModeSel
);
	// Test mode select held high, scan stays idle during configuration
	assign testModeSel = 1'b1;
	// Restart pin is active low
	assign programRestartN = ~progLow;
	// Wired init: pull-up unless either side pulls low
	assign initIn = initOe & ~holdInit;
	// Trigger held high until init is high
	assign rdCfgN = ~(trigLow & initIn);
	// Straps stay stable across the init edge
	assign modeIn = modeSet;
endmodule

// file: dv/tb_config_control_pins.sv
// Bench: restart, mode capture, 3-state, error pin, start-up, readback.
// Assumes the board model on the pins and a 100 MHz clock.
`timescale 1ns/1ns
module tb_config_control_pins
	import ccp_pkg::*;
;
	logic        clock = 0, rst = 1, progLow = 0, holdInit = 1, trigLow = 0;
	logic [3:0]  modeSet = 0, cfgMode, modeIn;
	logic        cfgEngineDone = 0, memInitErr = 0, hostIrqReq = 0, rbBit = 0, scanTdo = 0;
	logic        programRestartN, rdCfgN, initIn, initOe, doneOe, rdDataTdo, rbActive;
	logic        cfgIrqN, globalTristate, ioActive, scanReset, irq, regWr = 0, regRd = 0;
	logic [15:0] rbFrameAddr;
	logic        testModeSel;
	ccp_pins_t   pins;
	logic [7:0]  regAddr = 0, pll, clk;
	logic [31:0] regWdata = 0, regRdata, d;
	logic [3:0]  modes [4] = '{M_JTAG, M_SLAVE, M_MASTER, M_ASYNC};
	int          miscompares = 0, tests_run = 0, cyc = 0, n, scanCnt = 0;
	always #5 clock = ~clock;
	ccp_board_model brd (.initOe(initOe), .progLow(progLow), .holdInit(holdInit),
		.trigLow(trigLow), .modeSet(modeSet), .programRestartN(programRestartN),
		.rdCfgN(rdCfgN), .initIn(initIn), .modeIn(modeIn), .testModeSel(testModeSel));
	config_control_pins dut (.clock(clock), .rst(rst), .programRestartN(programRestartN),
		.rdCfgN(rdCfgN), .initIn(initIn), .initOut(), .initOe(initOe), .doneOut(),
		.doneOe(doneOe), .modeIn(modeIn), .cfgEngineDone(cfgEngineDone),
		.memInitErr(memInitErr), .hostIrqReq(hostIrqReq), .rbBit(rbBit), .scanTdo(scanTdo),
		.rdDataTdo(rdDataTdo), .rbActive(rbActive), .rbFrameAddr(rbFrameAddr),
		.cfgIrqN(cfgIrqN), .globalTristate(globalTristate), .ioActive(ioActive),
		.scanReset(scanReset), .cfgMode(cfgMode), .pins(pins), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
	task automatic summarize;
		$display("Checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (scanReset === 1'b1) scanCnt++;
		if (cyc == 20000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1;
		@(posedge clock);
		regWr <= 0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		regAddr <= a;
		regRd <= 1;
		@(posedge clock);
		regRd <= 0;
		@(posedge clock);
		v = regRdata;
	endtask
	task automatic restart(input logic [3:0] m);
		progLow <= 1;
		holdInit <= 1;
		modeSet <= m;
		repeat (6) @(posedge clock);
		chk("initOe", 0, initOe);
		chk("rbActive", 0, rbActive);
		progLow <= 0;
		for (n = 0; n < 100 && initOe !== 1'b1; n++) @(posedge clock);
		chk("initOe", 1, initOe);
		holdInit <= 0;
		repeat (6) @(posedge clock);
		chk("cfgMode", m, cfgMode);
		chk("cfgIrqN", 1, cfgIrqN);
		chk("scanReset", 1, scanCnt != 0);
		chk("pllPullup", 1, pins.pllPullup);
		chk("testModeSel", 1, testModeSel);
		scanCnt = 0;
	endtask
	initial begin
		void'($urandom(97));
		repeat (20) @(posedge clock);
		rst <= 0;
		@(posedge clock);
		chk("doneOe", 0, doneOe);
		chk("bscanEnable", 1, pins.bscanEnable);
		rd(A_CTRL, d);
		chk("ctrl", CTRL_RST, d);
		rd(A_DELAY, d);
		chk("delay", DELAY_RST, d);
		rd(8'h3c, d);
		chk("unmapped", 0, d);
		foreach (modes[i]) begin
			restart(modes[i]);
			memInitErr <= 1;
			trigLow <= 1;
			repeat (6) @(posedge clock);
			chk("cfgIrqN", 0, cfgIrqN);
			chk("globalTristate", 1, globalTristate);
			memInitErr <= 0;
			trigLow <= 0;
		end
		restart(4'hf);
		memInitErr <= 1;
		repeat (6) @(posedge clock);
		chk("cfgIrqN", 1, cfgIrqN);
		memInitErr <= 0;
		restart(modes[$urandom % 4]);
		pll = $urandom;
		clk = $urandom;
		wr(A_CTRL, 32'h1);
		wr(A_USE, {16'h0, clk, pll});
		wr(A_MASK, 0);
		cfgEngineDone <= 1;
		for (n = 0; n < 100 && doneOe !== 1'b1; n++) @(posedge clock);
		chk("ioActive", 0, ioActive);
		for (n = 0; n < 100 && ioActive !== 1'b1; n++) @(posedge clock);
		cfgEngineDone <= 0;
		repeat (2) @(posedge clock);
		chk("doneOe", 1, doneOe);
		chk("pllUserIo", {24'h0, ~pll}, pins.pllUserIo);
		chk("clkUserIo", {24'h0, ~clk}, pins.clkUserIo);
		chk("testUserIo", 1, pins.testUserIo);
		chk("bscanEnable", 0, pins.bscanEnable);
		rbBit <= $urandom;
		scanTdo <= $urandom;
		trigLow <= 1;
		for (n = 0; n < 20 && rbActive !== 1'b1; n++) @(posedge clock);
		chk("rbFrameAddr", 0, rbFrameAddr);
		@(posedge clock);
		chk("rdDataTdo", rbBit, rdDataTdo);
		for (n = 1; n < 200 && rbActive === 1'b1; n++) @(posedge clock);
		chk("rbLength", RB_BITS, n);
		repeat (20) @(posedge clock);
		chk("rbActive", 0, rbActive);
		chk("globalTristate", 0, globalTristate);
		chk("rdDataTdo", scanTdo, rdDataTdo);
		trigLow <= 0;
		rd(A_IRQ, d);
		chk("rbDoneEvent", 1, d[E_RBDONE]);
		wr(A_MASK, 32'h7);
		@(posedge clock);
		chk("irq", 1, irq);
		wr(A_MASK, 0);
		@(posedge clock);
		chk("irqMasked", 0, irq);
		wr(A_MASK, 32'h7);
		wr(A_IRQ, 32'h7);
		@(posedge clock);
		chk("irqCleared", 0, irq);
		wr(A_CTRL, 32'h9);
		hostIrqReq <= 1;
		repeat (4) @(posedge clock);
		chk("cfgIrqN", 0, cfgIrqN);
		hostIrqReq <= 0;
		repeat (4) @(posedge clock);
		chk("cfgIrqN", 1, cfgIrqN);
		trigLow <= 1;
		repeat (8) @(posedge clock);
		trigLow <= 0;
		restart(modes[0]);
		summarize();
	end
endmodule
